//--- hw/uscu_map.vh
`ifndef USCU_MAP_VH
`define USCU_MAP_VH
// Register offsets of the three channels (byte addresses on the bus)
`define USCU_CTRL0_ADDR   8'h95
`define USCU_BLO0_ADDR    8'h9d
`define USCU_BHI0_ADDR    8'h9e
`define USCU_DATA0_ADDR   8'h9f
`define USCU_CTRL1_ADDR   8'ha4
`define USCU_BLO1_ADDR    8'ha5
`define USCU_BHI1_ADDR    8'ha6
`define USCU_DATA1_ADDR   8'ha7
`define USCU_CTRL2_ADDR   8'hc4
`define USCU_BLO2_ADDR    8'hc5
`define USCU_BHI2_ADDR    8'hc6
`define USCU_DATA2_ADDR   8'hc7
// Mode select register, two bits per channel: [1:0] channel 0, [3:2] channel 1, [5:4] channel 2
`define USCU_MODESEL_ADDR 8'hf0
// Control register fields
`define USCU_F_SM0        7
`define USCU_F_SM1        6
`define USCU_F_MPS        5
`define USCU_F_REN        4
`define USCU_F_TB8        3
`define USCU_F_RB8        2
`define USCU_F_TI         1
`define USCU_F_RI         0
// Reset values
`define USCU_RST_BYTE     8'h00
// Frame modes
`define USCU_MODE_SHIFT   2'b00
`define USCU_MODE_ASYNC10 2'b01
`define USCU_MODE_ASYNC11 2'b11
`define USCU_SEL_UART     2'b11
// Shift-mode dividers
`define USCU_SHIFT_DIV12  16'h000c
`define USCU_SHIFT_DIV4   16'h0004
`endif

//--- hw/uscu_chan.v
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`include "uscu_map.vh"
module uscu_chan (
   // Clock and reset
   input  wire       i_clk,
   input  wire       i_rst_n,
   // Configuration
   input  wire       i_enable,
   input  wire [1:0] i_mode,
   input  wire       i_mps,
   input  wire       i_ren,
   input  wire       i_tb8,
   input  wire [15:0] i_div,
   // Transmit request
   input  wire       i_tx_start,
   input  wire [7:0] i_tx_data,
   // Events
   output reg        o_tx_done,
   output reg        o_rx_done,
   output reg  [7:0] o_rx_data,
   output reg        o_rx_b8,
   // Pins, already synchronised rx in
   input  wire       i_rx,
   output reg        o_tx,
   output reg        o_rx_out,
   output reg        o_rx_oe_n
);
   localparam S_IDLE = 3'b001;
   localparam S_TX   = 3'b010;
   localparam S_RX   = 3'b100;
   localparam R_IDLE = 2'b01;
   localparam R_RUN  = 2'b10;

   reg [2:0]  tx_state_reg;
   reg [15:0] tx_cnt_reg;
   reg [3:0]  tx_bit_reg;
   reg [10:0] tx_shift_reg;
   reg [1:0]  rx_state_reg;
   reg [15:0] rx_cnt_reg;
   reg [3:0]  rx_bit_reg;
   reg [8:0]  rx_shift_reg;
   reg        rx_prev_reg;
   reg        sh_phase_reg;

   wire        is_shift = (i_mode == `USCU_MODE_SHIFT);
   wire        is_11    = (i_mode == `USCU_MODE_ASYNC11);
   wire [15:0] shdiv    = i_mps ? `USCU_SHIFT_DIV4 : `USCU_SHIFT_DIV12;
   wire [15:0] bdiv     = is_shift ? {1'b0, shdiv[15:1]} : i_div;
   wire [3:0]  nbits    = is_shift ? 4'd8 : (is_11 ? 4'd11 : 4'd10);
   wire        tx_tick  = (tx_cnt_reg == bdiv - 16'h0001);

   // Transmitter; in shift mode the tx pin carries the shift clock
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_state_reg <= S_IDLE;
         tx_cnt_reg   <= 16'h0000;
         tx_bit_reg   <= 4'h0;
         tx_shift_reg <= 11'h7ff;
         sh_phase_reg <= 1'b0;
         o_tx         <= 1'b1;
         o_rx_out     <= 1'b1;
         o_rx_oe_n    <= 1'b1;
         o_tx_done    <= 1'b0;
      end else begin
         o_tx_done <= 1'b0;
         case (tx_state_reg)
            S_IDLE: begin
               o_tx      <= 1'b1;
               o_rx_oe_n <= 1'b1;
               if (i_tx_start && i_enable) begin
                  tx_state_reg <= S_TX;
                  tx_cnt_reg   <= 16'h0000;
                  tx_bit_reg   <= 4'h0;
                  sh_phase_reg <= 1'b0;
                  if (is_shift) begin
                     tx_shift_reg <= {3'b111, i_tx_data};
                     o_rx_oe_n    <= 1'b0;
                     o_rx_out     <= i_tx_data[0];
                  end else begin
                     // LSB first, low start, high stop
                     tx_shift_reg <= is_11 ? {1'b1, i_tb8, i_tx_data, 1'b0}
                                           : {2'b11, i_tx_data, 1'b0};
                     o_tx         <= 1'b0;
                  end
               end
            end
            S_TX: begin
               if (tx_tick) begin
                  tx_cnt_reg <= 16'h0000;
                  if (is_shift) begin
                     sh_phase_reg <= ~sh_phase_reg;
                     o_tx         <= sh_phase_reg;
                     if (sh_phase_reg) begin
                        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                        o_rx_out     <= tx_shift_reg[1];
                        tx_bit_reg   <= tx_bit_reg + 4'h1;
                     end
                  end else begin
                     tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                     o_tx         <= tx_shift_reg[1];
                     tx_bit_reg   <= tx_bit_reg + 4'h1;
                  end
                  if ((tx_bit_reg == nbits - 4'h1) && (!is_shift || sh_phase_reg)) begin
                     tx_state_reg <= S_IDLE;
                     o_tx         <= 1'b1;
                     o_rx_oe_n    <= 1'b1;
                     o_tx_done    <= 1'b1;
                  end
               end else begin
                  tx_cnt_reg <= tx_cnt_reg + 16'h0001;
               end
            end
            default: tx_state_reg <= S_IDLE;
         endcase
      end
   end

   // Asynchronous receiver; shift-mode reception is not supported here
   wire rx_mid  = (rx_cnt_reg == {1'b0, bdiv[15:1]});
   wire rx_end  = (rx_cnt_reg == bdiv - 16'h0001);
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_state_reg <= R_IDLE;
         rx_cnt_reg   <= 16'h0000;
         rx_bit_reg   <= 4'h0;
         rx_shift_reg <= 9'h000;
         rx_prev_reg  <= 1'b1;
         o_rx_done    <= 1'b0;
         o_rx_data    <= 8'h00;
         o_rx_b8      <= 1'b0;
      end else begin
         o_rx_done   <= 1'b0;
         rx_prev_reg <= i_rx;
         case (rx_state_reg)
            R_IDLE: begin
               // Falling edge on idle-high line
               if (i_enable && !is_shift && i_ren && rx_prev_reg && !i_rx) begin
                  rx_state_reg <= R_RUN;
                  rx_cnt_reg   <= 16'h0000;
                  rx_bit_reg   <= 4'h0;
               end
            end
            R_RUN: begin
               rx_cnt_reg <= rx_end ? 16'h0000 : rx_cnt_reg + 16'h0001;
               if (rx_mid) begin
                  if (rx_bit_reg == 4'h0 && i_rx) begin
                     rx_state_reg <= R_IDLE; // Glitch, not a start bit
                  end else if (rx_bit_reg == nbits - 4'h1) begin
                     rx_state_reg <= R_IDLE;
                     if (is_11) begin
                        o_rx_b8 <= rx_shift_reg[8];
                        o_rx_data <= rx_shift_reg[7:0];
                        o_rx_done <= !i_mps || rx_shift_reg[8];
                     end else begin
                        o_rx_data <= rx_shift_reg[8:1];
                        o_rx_done <= 1'b1;
                     end
                  end else begin
                     if (rx_bit_reg != 4'h0)
                        rx_shift_reg <= {i_rx, rx_shift_reg[8:1]};
                     rx_bit_reg <= rx_bit_reg + 4'h1;
                  end
               end
            end
            default: rx_state_reg <= R_IDLE;
         endcase
      end
   end
endmodule

//--- hw/uscu_uart.v
`timescale 1ns/1ps
`include "uscu_map.vh"
// Function
// - UART only when mode select is 11
// - Shift mode: data on rx, clock on tx
// - Mode 01: start, 8 data, stop
// - Mode 11: adds ninth bit; 10 reserved
// - Multiproc bit gates rx flag on ninth bit
// - Shift rate: twelfth or quarter of clock
// - Receive only while rx_permit set
// - Transmit tx_ninth_bit as ninth bit
// - Store received ninth bit
// - Hardware sets done flags, software clears
// - Baud equals clock over 16-bit divisor
// - Data write sends; read returns receive latch
module uscu_uart #(
   parameter NCH = 3
) (
   // Clock and reset
   input  wire          I_CLOCK,
   input  wire          I_RST_N,
   // Wishbone slave
   input  wire          I_WB_CYC,
   input  wire          I_WB_STB,
   input  wire          I_WB_WE,
   input  wire [7:0]    I_WB_ADR,
   input  wire [3:0]    I_WB_SEL,
   input  wire [31:0]   I_WB_DAT,
   output wire [31:0]   O_WB_DAT,
   output wire          O_WB_ACK,
   // Serial pins
   input  wire [NCH-1:0] I_RX,
   output wire [NCH-1:0] O_RX,
   output wire [NCH-1:0] O_RX_OE_N,
   output wire [NCH-1:0] O_TX
);
   reg  [7:0]     ctrl_reg [0:NCH-1];
   reg  [7:0]     blo_reg  [0:NCH-1];
   reg  [7:0]     bhi_reg  [0:NCH-1];
   reg  [1:0]     msel_reg [0:NCH-1];
   reg  [NCH-1:0] txgo_reg;
   reg  [7:0]     txd_reg;
   reg  [NCH-1:0] rx_s1_reg;
   reg  [NCH-1:0] rx_s2_reg;
   reg            ack_reg;
   reg  [7:0]     rdat_reg;
   wire [NCH-1:0] tx_done;
   wire [NCH-1:0] rx_done;
   wire [NCH-1:0] rx_b8;
   wire [8*NCH-1:0] rx_data;

   // Channel index and field of a byte address, 4'hf = none
   function [3:0] dec;
      input [7:0] a;
      begin
         if      (a == `USCU_CTRL0_ADDR) dec = {2'd0, 2'd0};
         else if (a == `USCU_BLO0_ADDR)  dec = {2'd0, 2'd1};
         else if (a == `USCU_BHI0_ADDR)  dec = {2'd0, 2'd2};
         else if (a == `USCU_DATA0_ADDR) dec = {2'd0, 2'd3};
         else if (a == `USCU_CTRL1_ADDR) dec = {2'd1, 2'd0};
         else if (a == `USCU_BLO1_ADDR)  dec = {2'd1, 2'd1};
         else if (a == `USCU_BHI1_ADDR)  dec = {2'd1, 2'd2};
         else if (a == `USCU_DATA1_ADDR) dec = {2'd1, 2'd3};
         else if (a == `USCU_CTRL2_ADDR) dec = {2'd2, 2'd0};
         else if (a == `USCU_BLO2_ADDR)  dec = {2'd2, 2'd1};
         else if (a == `USCU_BHI2_ADDR)  dec = {2'd2, 2'd2};
         else if (a == `USCU_DATA2_ADDR) dec = {2'd2, 2'd3};
         else                            dec = 4'hf;
      end
   endfunction

   // Byte registers sit in the low lane; each address is its own byte
   wire [3:0] d      = dec(I_WB_ADR);
   wire       req    = I_WB_CYC && I_WB_STB && !ack_reg;
   wire       wr     = req && I_WB_WE && I_WB_SEL[0];
   wire       is_ms  = (I_WB_ADR == `USCU_MODESEL_ADDR);
   assign O_WB_ACK = ack_reg;
   assign O_WB_DAT = {24'h000000, rdat_reg};

   integer k;
   always @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ack_reg   <= 1'b0;
         rdat_reg  <= `USCU_RST_BYTE;
         txgo_reg  <= {NCH{1'b0}};
         txd_reg   <= `USCU_RST_BYTE;
         rx_s1_reg <= {NCH{1'b1}};
         rx_s2_reg <= {NCH{1'b1}};
         for (k = 0; k < NCH; k = k + 1) begin
            ctrl_reg[k] <= `USCU_RST_BYTE;
            blo_reg[k]  <= `USCU_RST_BYTE;
            bhi_reg[k]  <= `USCU_RST_BYTE;
            msel_reg[k] <= 2'b00;
         end
      end else begin
         rx_s1_reg <= I_RX;
         rx_s2_reg <= rx_s1_reg;
         ack_reg   <= req;
         txgo_reg  <= {NCH{1'b0}};
         rdat_reg  <= 8'h00;
         if (req && !I_WB_WE) begin
            if (is_ms)
               rdat_reg <= {2'b00, msel_reg[2], msel_reg[1], msel_reg[0]};
            else if (d != 4'hf) begin
               if (d[1:0] == 2'd0)      rdat_reg <= ctrl_reg[d[3:2]];
               else if (d[1:0] == 2'd1) rdat_reg <= blo_reg[d[3:2]];
               else if (d[1:0] == 2'd2) rdat_reg <= bhi_reg[d[3:2]];
               else                     rdat_reg <= rx_data[8*d[3:2] +: 8];
            end
         end
         if (wr && is_ms) begin
            msel_reg[0] <= I_WB_DAT[1:0];
            msel_reg[1] <= I_WB_DAT[3:2];
            msel_reg[2] <= I_WB_DAT[5:4];
         end
         for (k = 0; k < NCH; k = k + 1) begin
            if (wr && d != 4'hf && d[3:2] == k) begin
               if (d[1:0] == 2'd0) ctrl_reg[k] <= I_WB_DAT[7:0];
               if (d[1:0] == 2'd1) blo_reg[k]  <= I_WB_DAT[7:0];
               if (d[1:0] == 2'd2) bhi_reg[k]  <= I_WB_DAT[7:0];
               if (d[1:0] == 2'd3) begin
                  txgo_reg[k] <= 1'b1;
                  txd_reg     <= I_WB_DAT[7:0];
               end
            end
            // Hardware set wins over a simultaneous software clear
            if (tx_done[k]) ctrl_reg[k][`USCU_F_TI] <= 1'b1;
            if (rx_done[k]) begin
               ctrl_reg[k][`USCU_F_RI] <= 1'b1;
               if (ctrl_reg[k][`USCU_F_SM0:`USCU_F_SM1] == `USCU_MODE_ASYNC11)
                  ctrl_reg[k][`USCU_F_RB8] <= rx_b8[k];
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : ch
         wire [1:0] md = ctrl_reg[g][`USCU_F_SM0:`USCU_F_SM1];
         // Reserved code 10 leaves the channel idle
         wire en = (msel_reg[g] == `USCU_SEL_UART) && (md != 2'b10);
         uscu_chan u_chan (
            .i_clk      (I_CLOCK),
            .i_rst_n    (I_RST_N),
            .i_enable   (en),
            .i_mode     (md),
            .i_mps      (ctrl_reg[g][`USCU_F_MPS]),
            .i_ren      (ctrl_reg[g][`USCU_F_REN]),
            .i_tb8      (ctrl_reg[g][`USCU_F_TB8]),
            .i_div      ({bhi_reg[g], blo_reg[g]}),
            .i_tx_start (txgo_reg[g]),
            .i_tx_data  (txd_reg),
            .o_tx_done  (tx_done[g]),
            .o_rx_done  (rx_done[g]),
            .o_rx_data  (rx_data[8*g +: 8]),
            .o_rx_b8    (rx_b8[g]),
            .i_rx       (rx_s2_reg[g]),
            .o_tx       (O_TX[g]),
            .o_rx_out   (O_RX[g]),
            .o_rx_oe_n  (O_RX_OE_N[g])
         );
      end
   endgenerate
endmodule

//--- tb/uscu_uart_monitor.sv
`timescale 1ns/1ps
`include "uscu_map.vh"
module uscu_uart_monitor #(
   parameter NCH = 3,
   parameter BIT = 17
) (
   input wire           I_CLOCK,
   input wire           I_RST_N,
   input wire           I_WB_CYC,
   input wire           I_WB_STB,
   input wire           I_WB_WE,
   input wire [7:0]     I_WB_ADR,
   input wire [3:0]     I_WB_SEL,
   input wire [31:0]    I_WB_DAT,
   input wire [31:0]    O_WB_DAT,
   input wire           O_WB_ACK,
   input wire [NCH-1:0] I_RX,
   input wire [NCH-1:0] O_RX,
   input wire [NCH-1:0] O_RX_OE_N,
   input wire [NCH-1:0] O_TX
);
   // Frame tracker so edges inside data bits are not taken as starts
   int frm;
   logic tx_q;
   logic [1:0] mode_q;
   always @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         frm <= 0;
         tx_q <= 1'b1;
         mode_q <= `USCU_MODE_SHIFT;
      end else begin
         tx_q <= O_TX[0];
         // Shadow of channel 0 frame mode; in shift mode the pin is a clock
         if (I_WB_CYC && I_WB_STB && I_WB_WE && I_WB_SEL[0] && !O_WB_ACK &&
             I_WB_ADR == `USCU_CTRL0_ADDR)
            mode_q <= I_WB_DAT[7:6];
         if (frm != 0)
            frm <= frm - 1;
         else if (tx_q && !O_TX[0] && mode_q != `USCU_MODE_SHIFT)
            frm <= ((mode_q == `USCU_MODE_ASYNC11) ? 11 : 10) * BIT - 1;
      end
   end
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RST_N);
   sequence start_seen;
      $fell(O_TX[0]) && frm == 0 && mode_q != `USCU_MODE_SHIFT;
   endsequence
   sequence start10;
      $fell(O_TX[0]) && frm == 0 && mode_q == `USCU_MODE_ASYNC10;
   endsequence
   sequence start11;
      $fell(O_TX[0]) && frm == 0 && mode_q == `USCU_MODE_ASYNC11;
   endsequence
   sequence start_held;
      (!O_TX[0]) [*8] ##9 !O_TX[0];
   endsequence
   sequence stop_held;
      ##153 O_TX[0] ##16 O_TX[0];
   endsequence
   sequence stop_held11;
      ##170 O_TX[0] ##16 O_TX[0];
   endsequence
   chk_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
      else $error("ack longer than one cycle");
   chk_ack_cause: assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB))
      else $error("ack without request");
   chk_req_answer: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
      else $error("request not answered");
   chk_no_spurious: assert property (!(I_WB_CYC && I_WB_STB) |=> !O_WB_ACK)
      else $error("ack while idle");
   chk_dat_idle: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0)
      else $error("read data outside ack");
   chk_dat_upper: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h0)
      else $error("upper read data not zero");
   chk_start_len: assert property (start_seen |-> start_held)
      else $error("start bit length wrong");
   chk_stop_high: assert property (start10 |-> stop_held)
      else $error("stop bit not high");
   chk_stop_eleven: assert property (start11 |-> stop_held11)
      else $error("stop bit of long frame not high");
   chk_idle_reset: assert property ($rose(I_RST_N) |-> O_TX == {NCH{1'b1}})
      else $error("tx not idle after reset");
endmodule

//--- tb/uscu_peer.sv
`timescale 1ns/1ps
module uscu_peer #(
   parameter BIT = 17
) (
   input  wire i_clk,
   input  wire i_tx,
   output reg  o_rx
);
   reg [8:0] got;
   reg [7:0] rx_byte;
   reg       rx_b9;
   int       k;
   initial o_rx = 1'b1;
   // Idle high, start low, LSB first, stop high
   task automatic send(input [7:0] d, input b9, input nine);
      reg [10:0] fr;
      fr = nine ? {1'b1, b9, d, 1'b0} : {2'b11, d, 1'b0};
      for (int b = 0; b < (nine ? 11 : 10); b++) begin
         @(posedge i_clk);
         o_rx <= fr[b];
         repeat (BIT - 1) @(posedge i_clk);
      end
   endtask
   // Mid-bit sampling; ninth sample is stop or ninth bit
   always begin
      @(negedge i_tx);
      repeat (BIT / 2) @(posedge i_clk);
      for (k = 0; k < 9; k++) begin
         repeat (BIT) @(posedge i_clk);
         got[k] = i_tx;
      end
      rx_byte = got[7:0];
      rx_b9 = got[8];
   end
endmodule

//--- tb/tb_uscu_uart.sv
`timescale 1ns/1ps
`include "uscu_map.vh"
module tb_uscu_uart;
   reg         I_CLOCK = 1'b0;
   reg         I_RST_N = 1'b0;
   reg         I_WB_CYC = 1'b0;
   reg         I_WB_STB = 1'b0;
   reg         I_WB_WE = 1'b0;
   reg  [7:0]  I_WB_ADR = 8'h00;
   reg  [3:0]  I_WB_SEL = 4'h0;
   reg  [31:0] I_WB_DAT = 32'h0;
   wire [31:0] O_WB_DAT;
   wire        O_WB_ACK;
   wire [2:0]  O_RX;
   wire [2:0]  O_RX_OE_N;
   wire [2:0]  O_TX;
   wire        peer_rx;
   wire [2:0]  I_RX = {2'b11, peer_rx};
   int         error_cnt = 0;
   int         comparisons = 0;
   int         i;
   reg  [7:0]  q;
   time        t0;
   reg  [7:0]  regs [0:11] = '{`USCU_CTRL0_ADDR, `USCU_BLO0_ADDR, `USCU_BHI0_ADDR,
      `USCU_DATA0_ADDR, `USCU_CTRL1_ADDR, `USCU_BLO1_ADDR, `USCU_BHI1_ADDR, `USCU_DATA1_ADDR,
      `USCU_CTRL2_ADDR, `USCU_BLO2_ADDR, `USCU_BHI2_ADDR, `USCU_DATA2_ADDR};
   always #5 I_CLOCK = ~I_CLOCK;
   uscu_uart uut (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_WB_CYC(I_WB_CYC),
      .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL),
      .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_RX(I_RX),
      .O_RX(O_RX), .O_RX_OE_N(O_RX_OE_N), .O_TX(O_TX));
   uscu_peer #(.BIT(17)) peer (.i_clk(I_CLOCK), .i_tx(O_TX[0]), .o_rx(peer_rx));
   task automatic end_of_test;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string name, input [7:0] seen, input [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Request held until ack is sampled high at a rising edge; the watchdog bounds the wait
   task automatic wb(input [7:0] a, input w, input [7:0] d);
      int n;
      @(posedge I_CLOCK);
      I_WB_CYC <= 1'b1;
      I_WB_STB <= 1'b1;
      I_WB_WE <= w;
      I_WB_ADR <= a;
      I_WB_SEL <= 4'h1;
      I_WB_DAT <= {24'h0, d};
      n = 0;
      do begin
         @(posedge I_CLOCK);
         n++;
      end while (O_WB_ACK !== 1'b1);
      check("ack latency", 8'(n), 8'h02);
      q = O_WB_DAT[7:0];
      I_WB_CYC <= 1'b0;
      I_WB_STB <= 1'b0;
      I_WB_WE <= 1'b0;
   endtask
   task automatic wait_flag(input [7:0] m);
      do begin
         wb(`USCU_CTRL0_ADDR, 1'b0, 8'h00);
      end while ((q & m) == 8'h00);
   endtask
   initial begin
      repeat (2000) @(posedge I_CLOCK);
      repeat (18000) @(posedge I_CLOCK);
      error_cnt++;
      end_of_test();
   end
   initial begin
      repeat (3) @(posedge I_CLOCK);
      I_RST_N <= 1'b1;
      for (i = 0; i < 12; i++) begin
         wb(regs[i], 1'b0, 8'h00);
         check("reset value", q, 8'h00);
      end
      wb(8'h10, 1'b1, 8'hff);
      wb(8'h10, 1'b0, 8'h00);
      check("unmapped", q, 8'h00);
      wb(`USCU_MODESEL_ADDR, 1'b1, 8'h3f);
      for (i = 0; i < 3; i++) begin
         wb(regs[i*4+2], 1'b1, 8'ha5);
         wb(regs[i*4+2], 1'b0, 8'h00);
         check("baud high", q, 8'ha5);
         wb(regs[i*4+2], 1'b1, 8'h00);
         wb(regs[i*4+1], 1'b1, 8'h11);
      end
      wb(`USCU_CTRL0_ADDR, 1'b1, 8'h40);
      wb(`USCU_DATA0_ADDR, 1'b1, 8'h5a);
      wait_flag(8'h02);
      wb(`USCU_CTRL0_ADDR, 1'b0, 8'h00);
      check("tx flag kept", q, 8'h42);
      check("tx byte", peer.rx_byte, 8'h5a);
      wb(`USCU_CTRL0_ADDR, 1'b1, 8'hc8);
      wb(`USCU_DATA0_ADDR, 1'b1, 8'ha3);
      wait_flag(8'h02);
      check("tx byte 11", peer.rx_byte, 8'ha3);
      check("tx ninth", {7'h0, peer.rx_b9}, 8'h01);
      wb(`USCU_CTRL0_ADDR, 1'b1, 8'h50);
      peer.send(8'hc3, 1'b0, 1'b0);
      wait_flag(8'h01);
      wb(`USCU_DATA0_ADDR, 1'b0, 8'h00);
      check("rx byte", q, 8'hc3);
      wb(`USCU_CTRL0_ADDR, 1'b1, 8'h40);
      peer.send(8'h3c, 1'b0, 1'b0);
      repeat (20) @(posedge I_CLOCK);
      wb(`USCU_CTRL0_ADDR, 1'b0, 8'h00);
      check("rx off flag", q, 8'h40);
      wb(`USCU_DATA0_ADDR, 1'b0, 8'h00);
      check("rx off data", q, 8'hc3);
      wb(`USCU_CTRL0_ADDR, 1'b1, 8'hf0);
      peer.send(8'h81, 1'b0, 1'b1);
      repeat (20) @(posedge I_CLOCK);
      wb(`USCU_CTRL0_ADDR, 1'b0, 8'h00);
      check("filtered", q, 8'hf0);
      peer.send(8'h96, 1'b1, 1'b1);
      wait_flag(8'h01);
      check("addr frame", q, 8'hf5);
      wb(`USCU_CTRL0_ADDR, 1'b1, 8'hd4);
      peer.send(8'h44, 1'b0, 1'b1);
      wait_flag(8'h01);
      check("ninth zero", q, 8'hd1);
      wb(`USCU_DATA0_ADDR, 1'b0, 8'h00);
      check("rx byte 11", q, 8'h44);
      wb(`USCU_CTRL0_ADDR, 1'b1, 8'h20);
      wb(`USCU_DATA0_ADDR, 1'b1, 8'h55);
      // Shift data changes on the rising clock, so it is read at the falling one
      for (i = 0; i < 8; i++) begin
         @(negedge O_TX[0]);
         if (i == 1)
            t0 = $time;
         if (i == 2)
            check("shift period", 8'(($time - t0) / 10), 8'h04);
         q[i] = O_RX[0];
         check("shift drive", {7'h0, O_RX_OE_N[0]}, 8'h00);
      end
      check("shift data", q, 8'h55);
      wait_flag(8'h02);
      wb(`USCU_CTRL0_ADDR, 1'b1, 8'h00);
      wb(`USCU_DATA0_ADDR, 1'b1, 8'ha6);
      @(negedge O_TX[0]);
      t0 = $time;
      @(negedge O_TX[0]);
      check("slow period", 8'(($time - t0) / 10), 8'h0c);
      wait_flag(8'h02);
      wb(`USCU_CTRL0_ADDR, 1'b1, 8'h80);
      wb(`USCU_DATA0_ADDR, 1'b1, 8'h0f);
      repeat (40) @(posedge I_CLOCK);
      wb(`USCU_CTRL0_ADDR, 1'b0, 8'h00);
      check("reserved flag", q, 8'h80);
      check("reserved idle", {7'h0, O_TX[0]}, 8'h01);
      end_of_test();
   end
endmodule
bind uscu_uart uscu_uart_monitor #(.NCH(NCH), .BIT(17)) u_mon (.I_CLOCK(I_CLOCK),
   .I_RST_N(I_RST_N), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE),
   .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT),
   .O_WB_ACK(O_WB_ACK), .I_RX(I_RX), .O_RX(O_RX), .O_RX_OE_N(O_RX_OE_N), .O_TX(O_TX));
